/* File: hw/pdio_cfg.svh */
// constants for the pci digital i/o port: offsets, resets, timing
`ifndef PDIO_CFG_SVH
`define PDIO_CFG_SVH

`define PDIO_NCH         32
`define PDIO_AW          8
// register byte offsets on the wishbone slave
`define PDIO_OFS_IN      8'h00
`define PDIO_OFS_OUT     8'h04
`define PDIO_OFS_EDGE    8'h08
`define PDIO_OFS_MASK    8'h0c
`define PDIO_OFS_STAT    8'h10
`define PDIO_OFS_FILT    8'h14
`define PDIO_OFS_OBACK   8'h18
// reset values
`define PDIO_RST_OUT     32'h0000_0000
`define PDIO_RST_EDGE    32'h0000_0000
`define PDIO_RST_MASK    32'hffff_ffff
`define PDIO_RST_STAT    32'h0000_0000
`define PDIO_RST_FILT    4'h0
`define PDIO_ZERO32      32'h0000_0000
// idle level of the field wires, all pulled up
`define PDIO_PIN_IDLE    32'hffff_ffff
// filter setting field
`define PDIO_FILT_W      4
`define PDIO_FILT_CNT_W  16
// filter base period 1/8 MHz, and the clock period, both in ns
`define PDIO_FILT_BASE_NS 32'd125
`define PDIO_CLK_NS       32'd100
`define PDIO_ONE32        32'h0000_0001
`define PDIO_CLK_ROUND    (`PDIO_CLK_NS - `PDIO_ONE32)

`endif

/* File: hw/pdio_pkg.sv */
// types shared by the pci digital i/o port and its bench
package pdio_pkg;
	// wishbone classic request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pdio_wb_req_t;

	// wishbone classic answer from the slave
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pdio_wb_rsp_t;

	// one open-drain pin group: level out, enable (low drives)
	typedef struct packed {
		logic [31:0] level;
		logic [31:0] oe_n;
	} pdio_od_t;
endpackage

/* File: hw/pdio_port.sv */
// pci digital i/o port: 32 inverted inputs, 32 open-collector outputs, edge interrupts
`timescale 1ns/100ps
`include "pdio_cfg.svh"

// How it works
// - input pins read inverted, high reads zero
// - written one pulls the output line low
// - all 32 inputs merge into one interrupt
// - interrupts fire on edges, never on levels
// - filter time is two-to-n over 8 MHz
// - host reaches registers as a 32-bit target
// - per-input edge select, zero after reset
// - status read clears status and interrupt request
// - masked input never sets its status bit
// - all status bits zero after reset
module pdio_port (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// wishbone register bus
	input  wire pdio_pkg::pdio_wb_req_t wb_req,
	output pdio_pkg::pdio_wb_rsp_t      wb_rsp,
	// field inputs, raw pin levels
	input  wire logic [31:0]           din_pin,
	// field outputs, open collector
	input  wire logic [31:0]           dout_in,
	output pdio_pkg::pdio_od_t          dout_pin,
	// interrupt request, open drain and plain level
	input  wire logic                  inta_in,
	output logic                       inta_out,
	output logic                       inta_oe_n,
	output logic                       irq
);

	// software-visible registers
	logic [31:0] out_data;     // 1 = transistor on
	logic [31:0] edge_sel;     // 0 = data rise, 1 = data fall
	logic [31:0] int_mask;     // 1 = interrupt disabled
	logic [31:0] int_stat;     // sticky edge flags
	logic [`PDIO_FILT_W-1:0] filt_n;  // filter setting n

	// pin synchronisers, filtered data and its last value
	logic [31:0] din_s1;
	logic [31:0] din_s2;
	logic [31:0] dback_s1;
	logic [31:0] dback_s2;
	logic [31:0] in_data;      // filtered, already inverted
	logic [31:0] in_prev;      // filtered data one cycle earlier
	logic [31:0] edge_hit;     // selected edge seen this cycle

	// bus decode
	logic        bus_req;      // valid request not yet answered
	logic        wr_en;
	logic        rd_stat;      // status read taken this cycle
	logic [31:0] wr_mask;      // byte enables spread to bits
	logic [31:0] next_rdata;
	logic [31:0] stat_w1c;     // bits written as one to status
	logic [31:0] filt_thresh;  // filter time in clock cycles

	// two flops on every pin before any logic looks at it;
	// reset to the pulled-up idle level so no false edge follows reset
	always_ff @(posedge clk) begin
		if (reset) begin
			din_s1   <= `PDIO_PIN_IDLE;
			din_s2   <= `PDIO_PIN_IDLE;
			dback_s1 <= `PDIO_PIN_IDLE;
			dback_s2 <= `PDIO_PIN_IDLE;
		end else begin
			din_s1   <= din_pin;
			din_s2   <= din_s1;
			dback_s1 <= dout_in;
			dback_s2 <= dback_s1;
		end
	end

	// filter time 2^n * 125 ns rounded up to whole 100 ns cycles
	always_comb begin
		filt_thresh = ((`PDIO_ONE32 << filt_n) * `PDIO_FILT_BASE_NS + `PDIO_CLK_ROUND)
			/ `PDIO_CLK_NS;
	end

	// per-input filter: a new level is taken only once it has held long enough
	genvar gi;
	generate
		for (gi = 0; gi < `PDIO_NCH; gi = gi + 1) begin : g_ch
			logic [`PDIO_FILT_CNT_W-1:0] stable_cnt;
			logic                        raw_data;
			assign raw_data = ~din_s2[gi];
			always_ff @(posedge clk) begin
				if (reset) begin
					stable_cnt  <= '0;
					in_data[gi] <= 1'b0;
				end else if (raw_data == in_data[gi]) begin
					// level agrees, restart the hold count
					stable_cnt <= '0;
				end else if (32'(stable_cnt) + `PDIO_ONE32 >= filt_thresh) begin
					// held long enough, accept it
					stable_cnt  <= '0;
					in_data[gi] <= raw_data;
				end else begin
					stable_cnt <= stable_cnt + 1'b1;
				end
			end
		end
	endgenerate

	// previous filtered data, for edge detection
	always_ff @(posedge clk) begin
		if (reset) begin
			in_prev <= `PDIO_ZERO32;
		end else begin
			in_prev <= in_data;
		end
	end

	// edges only: rise of data when select is 0, fall when 1
	assign edge_hit = (edge_sel & in_prev & ~in_data)
		| (~edge_sel & ~in_prev & in_data);

	// bus strobes; the answer comes one cycle after the request
	assign bus_req = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
	assign wr_en   = bus_req & wb_req.we;
	assign rd_stat = bus_req & ~wb_req.we & (wb_req.adr == `PDIO_OFS_STAT);
	assign wr_mask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
		{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
	assign stat_w1c = (wr_en && wb_req.adr == `PDIO_OFS_STAT)
		? (wb_req.dat & wr_mask) : `PDIO_ZERO32;

	// output data register
	always_ff @(posedge clk) begin
		if (reset) begin
			out_data <= `PDIO_RST_OUT;
		end else if (wr_en && wb_req.adr == `PDIO_OFS_OUT) begin
			out_data <= (out_data & ~wr_mask) | (wb_req.dat & wr_mask);
		end
	end

	// edge select register, cleared at reset
	always_ff @(posedge clk) begin
		if (reset) begin
			edge_sel <= `PDIO_RST_EDGE;
		end else if (wr_en && wb_req.adr == `PDIO_OFS_EDGE) begin
			edge_sel <= (edge_sel & ~wr_mask) | (wb_req.dat & wr_mask);
		end
	end

	// mask register; every input starts disabled so nothing fires early
	always_ff @(posedge clk) begin
		if (reset) begin
			int_mask <= `PDIO_RST_MASK;
		end else if (wr_en && wb_req.adr == `PDIO_OFS_MASK) begin
			int_mask <= (int_mask & ~wr_mask) | (wb_req.dat & wr_mask);
		end
	end

	// filter setting, low byte only
	always_ff @(posedge clk) begin
		if (reset) begin
			filt_n <= `PDIO_RST_FILT;
		end else if (wr_en && wb_req.adr == `PDIO_OFS_FILT && wb_req.sel[0]) begin
			filt_n <= wb_req.dat[`PDIO_FILT_W-1:0];
		end
	end

	// sticky status: read or write-one clears, a new edge wins over both
	always_ff @(posedge clk) begin
		if (reset) begin
			int_stat <= `PDIO_RST_STAT;
		end else if (rd_stat) begin
			int_stat <= edge_hit & ~int_mask;
		end else begin
			int_stat <= (int_stat & ~stat_w1c) | (edge_hit & ~int_mask);
		end
	end

	// read mux; unmapped addresses read zero and still get an ack
	always_comb begin
		if (wb_req.adr == `PDIO_OFS_IN) begin
			next_rdata = in_data;
		end else if (wb_req.adr == `PDIO_OFS_OUT) begin
			next_rdata = out_data;
		end else if (wb_req.adr == `PDIO_OFS_EDGE) begin
			next_rdata = edge_sel;
		end else if (wb_req.adr == `PDIO_OFS_MASK) begin
			next_rdata = int_mask;
		end else if (wb_req.adr == `PDIO_OFS_STAT) begin
			next_rdata = int_stat;
		end else if (wb_req.adr == `PDIO_OFS_FILT) begin
			next_rdata = {{(32-`PDIO_FILT_W){1'b0}}, filt_n};
		end else if (wb_req.adr == `PDIO_OFS_OBACK) begin
			// line level read back, low line reads one
			next_rdata = ~dback_s2;
		end else begin
			next_rdata = `PDIO_ZERO32;
		end
	end

	// ack and read data, one registered cycle after the request
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_rsp.ack <= 1'b0;
			wb_rsp.dat <= `PDIO_ZERO32;
		end else begin
			wb_rsp.ack <= bus_req;
			if (bus_req && !wb_req.we) begin
				wb_rsp.dat <= next_rdata;
			end
		end
	end

	// open collector outputs: drive low where a one is written
	always_ff @(posedge clk) begin
		if (reset) begin
			dout_pin.level <= `PDIO_ZERO32;
			dout_pin.oe_n  <= ~`PDIO_RST_OUT;
		end else begin
			dout_pin.level <= `PDIO_ZERO32;
			dout_pin.oe_n  <= ~out_data;
		end
	end

	// interrupt line: any set status bit that is not masked pulls it low, a level not a pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			irq       <= 1'b0;
			inta_out  <= 1'b0;
			inta_oe_n <= 1'b1;
		end else begin
			irq       <= |(int_stat & ~int_mask);
			inta_out  <= 1'b0;
			inta_oe_n <= ~|(int_stat & ~int_mask);
		end
	end

	// inta_in is the shared wire level, kept only for a future read-back
	logic inta_unused;
	assign inta_unused = inta_in;

endmodule

/* File: tb/pdio_chk.sv */
// concurrent checks on the digital i/o port pins
`timescale 1ns/100ps
module pdio_chk (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   reset,
	// register bus and pins
	input wire pdio_pkg::pdio_wb_req_t wb_req,
	input wire pdio_pkg::pdio_wb_rsp_t wb_rsp,
	input wire pdio_pkg::pdio_od_t     dout_pin,
	input wire logic                   inta_out,
	input wire logic                   inta_oe_n,
	input wire logic                   irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// request taken: strobe up while no ack pending
	wire tkn = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	property p_ack_next; tkn |=> wb_rsp.ack; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_once; wb_rsp.ack |=> !wb_rsp.ack; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_out_drive;
		tkn && wb_req.we && wb_req.adr == 8'h04 && wb_req.sel == 4'hf
		|=> ##1 dout_pin.oe_n == ~$past(wb_req.dat, 2);
	endproperty
	a_out_drive: assert property (p_out_drive) else $error("output drive");
	// open drain: only the enable ever moves
	property p_sink_only; dout_pin.level == 32'h0 && !inta_out; endproperty
	a_sink_only: assert property (p_sink_only) else $error("drives high");
	property p_inta_irq; inta_oe_n == !irq; endproperty
	a_inta_irq: assert property (p_inta_irq) else $error("inta vs irq");
	property p_stat_clr; tkn && !wb_req.we && wb_req.adr == 8'h10 |=> ##1 !irq; endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("read no clear");
	property p_rst_idle; $fell(reset) |-> !irq && inta_oe_n && &dout_pin.oe_n; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("reset state");
	property p_hole; tkn && !wb_req.we && wb_req.adr == 8'h1c |=> wb_rsp.dat == 32'h0; endproperty
	a_hole: assert property (p_hole) else $error("hole data");
endmodule

/* File: tb/pdio_field.sv */
// field wiring model: switches on inputs, pull-ups on outputs
`timescale 1ns/100ps
module pdio_field (
	// from the port and the bench
	input  wire pdio_pkg::pdio_od_t dout_pin,
	input  wire logic [31:0]        in_level,
	// resolved wire levels
	output logic [31:0]             dout_line,
	output logic [31:0]             din_pin
);
	// a sinking driver wins, else the pull-up holds the line high
	assign dout_line = dout_pin.oe_n | dout_pin.level;
	// switch levels reach the input pins directly
	assign din_pin = in_level;
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the digital i/o port
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, a, e); end end
module tb_top;
	logic                   clk = 1'b0;     // 10 MHz
	logic                   reset = 1'b1;   // sync, high
	pdio_pkg::pdio_wb_req_t req = '0;       // bus master
	pdio_pkg::pdio_wb_rsp_t rsp;            // slave answer
	pdio_pkg::pdio_od_t     dout_pin;       // output drive
	logic [31:0]            in_level = '1;  // switches, idle high
	logic [31:0]            din_pin;        // input wires
	logic [31:0]            dout_line;      // output wires
	logic                   inta_out;       // interrupt drive
	logic                   inta_oe_n;      // interrupt enable
	logic                   irq;            // plain interrupt
	logic [31:0]            rdat;           // last read data
	int                     num_errors = 0; // mismatches
	int                     cmp_count = 0;  // comparisons
	int                     cycles = 0;     // hang guard
	wire                    inta_line = inta_oe_n | inta_out; // pulled-up wire
	always #50 clk = ~clk;
	pdio_port DUT (.clk, .reset, .wb_req(req), .wb_rsp(rsp), .din_pin, .dout_in(dout_line),
		.dout_pin, .inta_in(inta_line), .inta_out, .inta_oe_n, .irq);
	pdio_field u_fld (.dout_pin, .in_level, .dout_line, .din_pin);
	// one classic cycle; waits for ack, then strobe low a cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b1, w, a, 4'hf, d};
		@(posedge clk);
		// no fixed wait: only the bench timeout ends a missing ack
		while (rsp.ack !== 1'b1) begin
			@(posedge clk);
		end
		rdat = rsp.dat;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask
	task automatic summarize();
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// the run needs under 1000 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// whole map after reset, hole at 0x1c included
		for (int a = 0; a < 32; a += 4) rd(8'(a), (a == 12) ? 32'hffff_ffff : 32'h0);
		`CHK(dout_pin.oe_n, 32'hffff_ffff)
		wb(1'b1, 8'h04, 32'ha5a5_00ff);
		in_level <= 32'h0f0f_3c3e;
		repeat (8) @(posedge clk);
		`CHK(dout_pin.oe_n, 32'h5a5a_ff00)
		rd(8'h18, 32'ha5a5_00ff);
		rd(8'h00, 32'hf0f0_c3c1);
		// bit1 on data fall, bit31 masked, rest on data rise
		in_level <= '1;
		wb(1'b1, 8'h08, 32'h0000_0002);
		wb(1'b1, 8'h0c, 32'h8000_0000);
		repeat (8) @(posedge clk);
		in_level <= ~32'h8000_0007;
		repeat (12) @(posedge clk);
		`CHK({irq, inta_line}, 2'b10)
		rd(8'h10, 32'h0000_0005);
		repeat (3) @(posedge clk);
		`CHK({irq, inta_line}, 2'b01)
		in_level <= '1;
		repeat (12) @(posedge clk);
		rd(8'h10, 32'h0000_0002);
		// n=3: 1000 ns, ten cycles; a nine-cycle glitch is dropped
		wb(1'b1, 8'h14, 32'h0000_0003);
		in_level <= ~32'h0000_0020;
		repeat (9) @(posedge clk);
		in_level <= '1;
		repeat (20) @(posedge clk);
		rd(8'h00, 32'h0000_0000);
		in_level <= ~32'h0000_0020;
		repeat (16) @(posedge clk);
		rd(8'h00, 32'h0000_0020);
		// accepted level rose on bit5, unmasked: status set, then write-one clears it
		`CHK(irq, 1'b1)
		wb(1'b1, 8'h10, 32'h0000_0020);
		`CHK({irq, inta_line}, 2'b01)
		rd(8'h10, 32'h0000_0000);
		summarize();
	end
endmodule
bind pdio_port pdio_chk u_chk (.clk, .reset, .wb_req, .wb_rsp, .dout_pin, .inta_out,
	.inta_oe_n, .irq);
